// ==== include/etb_pkg.sv ====
`default_nettype none
// ----------------------------------------
// shared constants for trace and break control
// ----------------------------------------
package etb_pkg;
   // apb register byte offsets
   localparam logic [7:0] A_CMD   = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_CTRL  = 8'h08;
   localparam logic [7:0] A_BP0   = 8'h0C;
   localparam logic [7:0] A_BP1   = 8'h10;
   localparam logic [7:0] A_TIMER = 8'h14;
   localparam logic [7:0] A_MMAP  = 8'h18;
   localparam logic [7:0] A_IMAP  = 8'h1C;
   localparam logic [7:0] A_TIDX  = 8'h20;
   localparam logic [7:0] A_TDAT  = 8'h24;
   localparam logic [7:0] A_PINS  = 8'h28;
   // command, control and status bit positions
   localparam int CMD_RUN  = 0;
   localparam int CMD_STOP = 1;
   localparam int CTL_TO   = 0;
   localparam int CTL_BP0  = 1;
   localparam int CTL_PRB  = 3;
   localparam int ST_RUN   = 0;
   localparam int ST_NOTE  = 1;
   localparam int ST_ERR   = 2;
   localparam int ST_CLK   = 3;
   localparam int ST_CAUSE = 8;
   localparam int ST_CNT   = 16;
   // break cause bits
   localparam int C_BP0  = 0;
   localparam int C_PRB  = 2;
   localparam int C_GRD  = 3;
   localparam int C_TO   = 4;
   localparam int C_HOST = 5;
   localparam int CAUSE_W = 6;
   // reset values: timeout on, every block guarded
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] MAP_RST  = 32'hFFFF_0000;
   // sizes
   localparam int BP_W     = 24;
   localparam int NUM_BP   = 2;
   localparam int TMR_W    = 16;
   localparam int TRC_DEPTH = 44;
   localparam int TRC_AW   = 6;
   localparam int TRC_W    = 32;
   localparam int PIN_W    = 8;
   localparam int MAP_NX   = 16;
   localparam int MEM_LSB  = 12;
   localparam int IO_LSB   = 4;
   // timing
   localparam int CLK_HZ   = 25_000_000;
   localparam int EMU_HZ   = 2_000_000;
   localparam int INT_DIV  = CLK_HZ / EMU_HZ;
   localparam int TO_MS    = 250;
   localparam int TO_CYC   = (CLK_HZ / 1000) * TO_MS;
   typedef enum logic [1:0] {
      ETB_IDLE = 2'b00,
      ETB_RUN  = 2'b01,
      ETB_BRK  = 2'b10,
      ETB_XFER = 2'b11
   } etb_state_e;
endpackage : etb_pkg
`default_nettype wire

// ==== include/etb_trace_if.sv ====
`default_nettype none
// ----------------------------------------
// trace memory port bundle
// ----------------------------------------
interface etb_trace_if;
   logic                       wr_en;
   logic [etb_pkg::TRC_AW-1:0] wr_addr;
   logic [etb_pkg::TRC_W-1:0]  wr_data;
   logic [etb_pkg::TRC_AW-1:0] rd_addr;
   logic [etb_pkg::TRC_W-1:0]  rd_data;
   modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : etb_trace_if
`default_nettype wire

// ==== design/etb_trace_mem.sv ====
`default_nettype none
// ----------------------------------------
// cycle record store, registered read
// ----------------------------------------
module etb_trace_mem (
   input wire logic core_clk, // system clock
   input wire logic nrst,     // sync reset, active low
   input wire logic ce,       // clock enable
   etb_trace_if.mem tif       // write and read port
);
   logic [etb_pkg::TRC_W-1:0] mem [etb_pkg::TRC_DEPTH];

   // storage carries no reset; an index past the records written reads an unwritten entry
   always_ff @(posedge core_clk) begin
      if (ce && tif.wr_en) begin
         mem[tif.wr_addr] <= tif.wr_data;
      end
   end

   // read data from a flop so the bus mux sees a clean value
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tif.rd_data <= '0;
      end else if (ce) begin
         tif.rd_data <= mem[tif.rd_addr];
      end
   end
endmodule : etb_trace_mem
`default_nettype wire

// ==== design/etb_bp_cmp.sv ====
`default_nettype none
// ----------------------------------------
// breakpoint comparators
// ----------------------------------------
module etb_bp_cmp #(
   parameter int NUM = etb_pkg::NUM_BP, // comparator count
   parameter int W   = etb_pkg::BP_W    // compared width
) (
   input wire logic [NUM*W-1:0] bp_vals, // packed breakpoints
   input wire logic [W-1:0]     key,     // status and address
   input wire logic [NUM-1:0]   en,      // per comparator enable
   output logic     [NUM-1:0]   hit      // match per comparator
);
   // every bit must match, no masking
   for (genvar i = 0; i < NUM; i++) begin : g_cmp
      assign hit[i] = en[i] && (bp_vals[i*W +: W] == key); // R25
   end
endmodule : etb_bp_cmp
`default_nettype wire

// ==== design/etb_ctrl.sv ====
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
// ----------------------------------------
// emulation trace and break control
// ----------------------------------------
// Notes on behaviour
// [R1] host commands and emulator status pass through bus registers
// [R2] each emulated machine cycle is recorded while running
// [R3] two 24-bit breakpoint registers loadable before a run
// [R4] status and address compared each cycle; a match ends the run
// [R5] probe going true raises a break
// [R6] processor is notified of host commands and breaks
// [R7] processor copies trace, pins and cause to host memory
// [R8] error conditions reported with break information
// [R9] timer counts phase-two clock ticks only while running
// [R10] emulation starts only on the host start command
// [R11] access to a nonexistent block ends the run
// [R12] quarter second of inactivity ends the run
// [R13] inactivity timeout switchable by host setting
// [R14] block map holds host or target location of each block
// [R15] each access steered to host or target bus by the map
// [R16] emulator processor may master the host bus
// [R17] at break, pins latched then trace transfer commanded
// [R18] target bus driving disabled from break until next run
// [R19] emulated clock internal 2 MHz or derived from target
// [R20] clock source fixed by board strap, not by software
// [R21] cable drivers drive the socket only when enabled
// [R22] trace keeps the newest 44 cycles, overwriting older
// [R23] elapsed timer is 16 bits
// [R24] sixteen 4K memory and sixteen 16-port io blocks
// [R25] full 24-bit match; break cause recorded for host
module etb_ctrl #(
   parameter int unsigned TO_CYCLES = etb_pkg::TO_CYC // inactivity limit
) (
   input wire logic        core_clk,      // system clock
   input wire logic        nrst,          // sync reset, active low
   input wire logic        ce,            // clock enable
   input wire logic        psel,          // apb select
   input wire logic        penable,       // apb enable
   input wire logic        pwrite,        // apb direction
   input wire logic [7:0]  paddr,         // apb byte address
   input wire logic [31:0] pwdata,        // apb write data
   output logic            pready,        // apb ready
   output logic     [31:0] prdata,        // apb read data
   output logic            pslverr,       // apb error
   input wire logic        clk_sel_strap, // board strap: 1 = target clock
   input wire logic        tgt_clk,       // target-derived clock level
   output logic            emu_tick,      // phase-two tick to emulated cpu
   input wire logic        cyc_valid,     // machine cycle strobe
   input wire logic        cyc_io,        // cycle is an io access
   input wire logic [7:0]  cyc_status,    // cpu status byte
   input wire logic [15:0] cyc_addr,      // cycle address
   input wire logic [7:0]  cyc_data,      // cycle data
   input wire logic        cpu_active,    // cpu not waiting or halted
   input wire logic        probe,         // user probe level
   input wire logic [7:0]  pins_in,       // selected cpu pin states
   output logic            emu_run,       // emulation running
   output logic            route_tgt,     // access goes to target bus
   output logic            tgt_drive_en,  // cable driver enable
   output logic            hbus_req,      // host bus master request
   input wire logic        hbus_gnt,      // host bus granted
   output logic            notify,        // command or break pending
   input wire logic        proc_ack,      // processor took notification
   output logic            xfer_req,      // trace transfer command
   input wire logic        xfer_done      // status block copied
);
   localparam int TOW = $clog2(TO_CYCLES + 1);
   localparam int DW  = $clog2(etb_pkg::INT_DIV);

   etb_pkg::etb_state_e st_reg, st_next;
   etb_trace_if tif ();

   logic [31:0] ctrl_reg, mmap_reg, imap_reg, rd_mux;
   logic [etb_pkg::BP_W-1:0] bp_reg [etb_pkg::NUM_BP];
   logic [etb_pkg::NUM_BP*etb_pkg::BP_W-1:0] bp_pack;
   logic [etb_pkg::NUM_BP-1:0] bp_hit;
   logic [etb_pkg::TMR_W-1:0] tmr_reg;
   logic [etb_pkg::TRC_AW-1:0] wptr_reg, tidx_reg, oldest;
   logic [etb_pkg::TRC_AW:0] rsum;
   logic [etb_pkg::PIN_W-1:0] pins_reg;
   logic [etb_pkg::CAUSE_W-1:0] cause_reg, cause_new;
   logic [TOW-1:0] to_cnt_reg;
   logic [DW-1:0] div_reg;
   logic [31:0] map_sel;
   logic [3:0] blk;
   logic full_reg, err_reg, cmd_flag_reg, brk_flag_reg;
   logic clk_sel_reg, sel_cap_reg, tgt_prev_reg, prb_prev_reg;
   logic int_tick, acc_wr, mapped, run_go, stop_go;
   logic acc_guard, live, brk_any, to_hit;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // ready follows ce so a frozen block never completes a transfer
   assign pready = ce;
   assign acc_wr = psel && penable && pwrite && ce;
   assign pslverr = psel && penable && !mapped;

   // decode; unmapped offsets answer with an error and zero data
   always_comb begin
      mapped = 1'b1;
      rd_mux = '0;
      unique case (paddr)
         etb_pkg::A_CMD:   rd_mux = '0;
         etb_pkg::A_STAT: begin
            rd_mux[etb_pkg::ST_RUN] = emu_run; // R1
            rd_mux[etb_pkg::ST_NOTE] = notify;
            rd_mux[etb_pkg::ST_ERR] = err_reg; // R8
            rd_mux[etb_pkg::ST_CLK] = clk_sel_reg;
            rd_mux[etb_pkg::ST_CAUSE +: etb_pkg::CAUSE_W] = cause_reg; // R25
            rd_mux[etb_pkg::ST_CNT +: etb_pkg::TRC_AW] =
               full_reg ? etb_pkg::TRC_AW'(etb_pkg::TRC_DEPTH) : wptr_reg;
         end
         etb_pkg::A_CTRL:  rd_mux = ctrl_reg;
         etb_pkg::A_BP0:   rd_mux = {8'h00, bp_reg[0]};
         etb_pkg::A_BP1:   rd_mux = {8'h00, bp_reg[1]};
         etb_pkg::A_TIMER: rd_mux = {16'h0000, tmr_reg};
         etb_pkg::A_MMAP:  rd_mux = mmap_reg;
         etb_pkg::A_IMAP:  rd_mux = imap_reg;
         etb_pkg::A_TIDX:  rd_mux = {26'h0, tidx_reg};
         etb_pkg::A_TDAT:  rd_mux = tif.rd_data; // R7
         etb_pkg::A_PINS:  rd_mux = {24'h0, pins_reg};
         default:          mapped = 1'b0;
      endcase
   end

   // read data captured in the setup phase
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata <= '0;
      end else if (ce && psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // host command decode
   assign run_go = acc_wr && (paddr == etb_pkg::A_CMD) &&
                   pwdata[etb_pkg::CMD_RUN] && (st_reg == etb_pkg::ETB_IDLE);
   assign stop_go = acc_wr && (paddr == etb_pkg::A_CMD) && pwdata[etb_pkg::CMD_STOP];

   // configuration registers, writable at any time
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_reg <= etb_pkg::CTRL_RST;
         mmap_reg <= etb_pkg::MAP_RST;
         imap_reg <= etb_pkg::MAP_RST;
         bp_reg[0] <= '0;
         bp_reg[1] <= '0;
         tidx_reg <= '0;
      end else if (acc_wr) begin
         unique case (paddr)
            etb_pkg::A_CTRL: ctrl_reg <= pwdata; // R13
            etb_pkg::A_BP0:  bp_reg[0] <= pwdata[etb_pkg::BP_W-1:0]; // R3
            etb_pkg::A_BP1:  bp_reg[1] <= pwdata[etb_pkg::BP_W-1:0]; // R3
            etb_pkg::A_MMAP: mmap_reg <= pwdata; // R14
            etb_pkg::A_IMAP: imap_reg <= pwdata; // R14
            etb_pkg::A_TIDX: begin
               // indices past the record depth are dropped
               if (pwdata[31:0] < 32'(etb_pkg::TRC_DEPTH)) begin
                  tidx_reg <= pwdata[etb_pkg::TRC_AW-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // clock source and phase-two tick
   // ----------------------------------------
   // strap caught once after reset so software cannot change it
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sel_cap_reg <= 1'b0;
         clk_sel_reg <= 1'b0;
      end else if (ce && !sel_cap_reg) begin
         sel_cap_reg <= 1'b1;
         clk_sel_reg <= clk_sel_strap; // R20
      end
   end

   // internal generator; integer divide lands a little above 2 MHz
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         div_reg <= '0;
         tgt_prev_reg <= 1'b0;
      end else if (ce) begin
         div_reg <= int_tick ? '0 : div_reg + 1'b1;
         tgt_prev_reg <= tgt_clk;
      end
   end
   assign int_tick = (div_reg == DW'(etb_pkg::INT_DIV - 1));
   assign emu_tick = ce && (clk_sel_reg ? (tgt_clk && !tgt_prev_reg) : int_tick); // R19

   // ----------------------------------------
   // block map and bus steering
   // ----------------------------------------
   always_comb begin
      map_sel = cyc_io ? imap_reg : mmap_reg;
      blk = cyc_io ? cyc_addr[etb_pkg::IO_LSB +: 4] : cyc_addr[etb_pkg::MEM_LSB +: 4]; // R24
   end
   assign route_tgt = map_sel[blk]; // R15
   assign acc_guard = map_sel[etb_pkg::MAP_NX + 32'(blk)];
   // target side is quiet outside a run
   assign tgt_drive_en = emu_run && route_tgt; // R18 R21
   // host bus is borrowed for host-mapped accesses and the copy-out
   assign hbus_req = (emu_run && cyc_valid && !route_tgt) ||
                     (st_reg == etb_pkg::ETB_XFER); // R16
   assign xfer_req = (st_reg == etb_pkg::ETB_XFER) && hbus_gnt; // R17

   // ----------------------------------------
   // break detection
   // ----------------------------------------
   assign emu_run = (st_reg == etb_pkg::ETB_RUN);
   assign live = ce && emu_run;
   assign bp_pack = {bp_reg[1], bp_reg[0]};

   etb_bp_cmp #(
      .NUM (etb_pkg::NUM_BP),
      .W   (etb_pkg::BP_W)
   ) u_cmp (
      .bp_vals (bp_pack),
      .key     ({cyc_status, cyc_addr}),
      .en      ({2{cyc_valid}} & ctrl_reg[etb_pkg::CTL_BP0 +: etb_pkg::NUM_BP]),
      .hit     (bp_hit)
   );

   assign to_hit = ctrl_reg[etb_pkg::CTL_TO] && !cpu_active &&
                   (to_cnt_reg == TOW'(TO_CYCLES - 1)); // R13

   // several causes in one cycle are all kept
   always_comb begin
      cause_new = '0;
      cause_new[etb_pkg::C_BP0 +: etb_pkg::NUM_BP] = bp_hit; // R4
      cause_new[etb_pkg::C_PRB] = ctrl_reg[etb_pkg::CTL_PRB] && probe && !prb_prev_reg; // R5
      cause_new[etb_pkg::C_GRD] = cyc_valid && acc_guard; // R11
      cause_new[etb_pkg::C_TO] = to_hit; // R12
      cause_new[etb_pkg::C_HOST] = stop_go;
   end
   assign brk_any = |cause_new;

   // inactivity counter restarts on any activity
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         to_cnt_reg <= '0;
         prb_prev_reg <= 1'b0;
      end else if (ce) begin
         prb_prev_reg <= probe;
         if (!emu_run || cpu_active) begin
            to_cnt_reg <= '0;
         end else if (to_cnt_reg != TOW'(TO_CYCLES - 1)) begin
            to_cnt_reg <= to_cnt_reg + 1'b1; // R12
         end
      end
   end

   // ----------------------------------------
   // run control
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         etb_pkg::ETB_IDLE: if (run_go) st_next = etb_pkg::ETB_RUN; // R10
         etb_pkg::ETB_RUN:  if (brk_any) st_next = etb_pkg::ETB_BRK; // R4
         etb_pkg::ETB_BRK:  st_next = etb_pkg::ETB_XFER; // R17
         etb_pkg::ETB_XFER: if (xfer_done) st_next = etb_pkg::ETB_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_reg <= etb_pkg::ETB_IDLE;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // cause and error held from the break until the next start
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cause_reg <= '0;
         err_reg <= 1'b0;
      end else if (ce && run_go) begin
         cause_reg <= '0;
         err_reg <= 1'b0;
      end else if (live && brk_any) begin
         cause_reg <= cause_new; // R25
         err_reg <= cause_new[etb_pkg::C_GRD]; // R8
      end
   end

   // pin states frozen at the break
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pins_reg <= '0;
      end else if (ce && st_reg == etb_pkg::ETB_BRK) begin
         pins_reg <= pins_in; // R17
      end
   end

   // notification; a new event wins over an ack in the same cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cmd_flag_reg <= 1'b0;
         brk_flag_reg <= 1'b0;
      end else if (ce) begin
         if (acc_wr && paddr == etb_pkg::A_CMD) begin
            cmd_flag_reg <= 1'b1; // R6
         end else if (proc_ack) begin
            cmd_flag_reg <= 1'b0;
         end
         if (st_reg == etb_pkg::ETB_BRK) begin
            brk_flag_reg <= 1'b1; // R6
         end else if (proc_ack) begin
            brk_flag_reg <= 1'b0;
         end
      end
   end
   assign notify = cmd_flag_reg || brk_flag_reg;

   // elapsed time in phase-two ticks, wraps at 16 bits
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tmr_reg <= '0;
      end else if (run_go) begin
         tmr_reg <= '0;
      end else if (live && emu_tick) begin
         tmr_reg <= tmr_reg + 1'b1; // R9 R23
      end
   end

   // ----------------------------------------
   // trace capture
   // ----------------------------------------
   assign tif.wr_en = live && cyc_valid; // R2
   assign tif.wr_addr = wptr_reg;
   assign tif.wr_data = {cyc_status, cyc_addr, cyc_data};

   // circular pointer: once full the oldest record is overwritten
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wptr_reg <= '0;
         full_reg <= 1'b0;
      end else if (tif.wr_en) begin
         if (wptr_reg == etb_pkg::TRC_AW'(etb_pkg::TRC_DEPTH - 1)) begin
            wptr_reg <= '0;
            full_reg <= 1'b1; // R22
         end else begin
            wptr_reg <= wptr_reg + 1'b1;
         end
      end
   end

   // index 0 reads the oldest record held
   always_comb begin
      oldest = full_reg ? wptr_reg : '0;
      rsum = {1'b0, oldest} + {1'b0, tidx_reg};
      tif.rd_addr = (rsum >= (etb_pkg::TRC_AW + 1)'(etb_pkg::TRC_DEPTH)) ?
         etb_pkg::TRC_AW'(rsum - (etb_pkg::TRC_AW + 1)'(etb_pkg::TRC_DEPTH)) :
         etb_pkg::TRC_AW'(rsum);
   end

   etb_trace_mem u_mem (
      .core_clk (core_clk),
      .nrst     (nrst),
      .ce       (ce),
      .tif      (tif.mem)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence brk_seen;
      ce && st_reg == etb_pkg::ETB_BRK;
   endsequence
   sequence copy_out;
      st_reg == etb_pkg::ETB_XFER && pins_reg == $past(pins_in) && notify;
   endsequence

   start_on_cmd_a: assert property ($rose(emu_run) |-> $past(acc_wr) && $past(paddr) == etb_pkg::A_CMD // R10
      && $past(pwdata[etb_pkg::CMD_RUN]))
      else $error("run began without start command");
   bp_break_a: assert property (live && |bp_hit |=> !emu_run && |cause_reg[1:0]) // R4
      else $error("breakpoint match did not end run");
   probe_break_a: assert property (live && ctrl_reg[etb_pkg::CTL_PRB] && $rose(probe)
      |=> cause_reg[etb_pkg::C_PRB] && st_reg == etb_pkg::ETB_BRK) // R5
      else $error("probe did not break");
   guard_break_a: assert property (live && cyc_valid && acc_guard |=> err_reg ##1 !emu_run) // R11
      else $error("guarded access did not break");
   tgt_quiet_a: assert property (!emu_run |-> !tgt_drive_en) // R18
      else $error("target driven outside a run");
   pin_latch_a: assert property (brk_seen |=> copy_out) // R17
      else $error("pins not latched before copy-out");
   timer_hold_a: assert property (!emu_run && !run_go |=> $stable(tmr_reg)) // R9
      else $error("timer moved outside a run");
   trace_step_a: assert property (tif.wr_en && wptr_reg == 6'h0A |=> wptr_reg == 6'h0B) // R2
      else $error("trace pointer did not advance");
   trace_wrap_a: assert property (tif.wr_en && wptr_reg == 6'h2B |=> wptr_reg == 6'h00 && full_reg) // R22
      else $error("trace did not wrap at 44");
   timeout_a: assert property (live && to_hit |=> cause_reg[etb_pkg::C_TO] && !emu_run) // R12
      else $error("inactivity timeout missed");
   to_off_a: assert property (live && !ctrl_reg[etb_pkg::CTL_TO] |=> !cause_reg[etb_pkg::C_TO]) // R13
      else $error("disabled timeout fired");
   cmd_note_a: assert property (acc_wr && paddr == etb_pkg::A_CMD |=> notify ##1 (notify || $past(proc_ack))) // R6
      else $error("command not notified");
endmodule : etb_ctrl
`default_nettype wire

// ==== verif/etb_host_model.sv ====
`default_nettype none
// ----------------------------------------
// host arbiter and emulator processor
// ----------------------------------------
module etb_host_model #(
   parameter int DLY = 3 // answer delay
) (
   input wire logic core_clk,  // clock
   input wire logic nrst,      // reset
   input wire logic hbus_req,  // request
   input wire logic notify,    // event
   input wire logic xfer_req,  // copy cmd
   output logic     hbus_gnt,  // grant
   output logic     proc_ack,  // event taken
   output logic     xfer_done  // copy done
);
   timeunit 1ns;
   timeprecision 1ps;
   int acnt;
   int xcnt;
   // answers come late on purpose, so the design has to hold its requests
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hbus_gnt  <= 1'b0;
         proc_ack  <= 1'b0;
         xfer_done <= 1'b0;
         acnt      <= 0;
         xcnt      <= 0;
      end else begin
         hbus_gnt  <= hbus_req;
         acnt      <= (notify && !proc_ack) ? acnt + 1 : 0;
         proc_ack  <= notify && acnt == DLY && !proc_ack;
         xcnt      <= (xfer_req && !xfer_done) ? xcnt + 1 : 0;
         xfer_done <= xfer_req && xcnt == DLY && !xfer_done;
      end
   end
endmodule : etb_host_model
`default_nettype wire

// ==== verif/emulation_trace_break_control_tb.sv ====
`default_nettype none
// ----------------------------------------
// trace and break control bench
// ----------------------------------------
module emulation_trace_break_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, serr;
   logic        cyc_valid = 0, cyc_io = 0, cpu_active = 1, probe = 0, strap = 0;
   logic [7:0]  paddr = 0, cyc_status = 0, cyc_data = 0;
   logic [15:0] cyc_addr = 0;
   logic [31:0] pwdata = 0, q, t;
   wire logic   pready, pslverr, emu_tick, emu_run, route_tgt, tgt_drive_en;
   wire logic   hbus_req, hbus_gnt, notify, proc_ack, xfer_req, xfer_done;
   wire logic [31:0] prdata;
   int          err_total = 0, comparisons = 0;
   // strap moves only after its capture, so the internal clock must stay selected
   etb_ctrl #(.TO_CYCLES(20)) dut (.core_clk, .nrst, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .clk_sel_strap(strap), .tgt_clk(1'b0), .emu_tick, .cyc_valid,
      .cyc_io, .cyc_status, .cyc_addr, .cyc_data, .cpu_active, .probe, .pins_in(8'hA5), .emu_run,
      .route_tgt, .tgt_drive_en, .hbus_req, .hbus_gnt, .notify, .proc_ack, .xfer_req, .xfer_done);
   etb_host_model host (.core_clk, .nrst, .hbus_req, .notify, .xfer_req, .hbus_gnt, .proc_ack, .xfer_done);
   always #20 core_clk = ~core_clk;
   task conclude;
      $display("Checks %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one apb transfer; request held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      {psel, penable, pwrite} <= {2'b10, w};
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      serr = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50) begin
         err_total++;
         conclude();
      end
   endtask : apb
   // one machine cycle strobe with the expected bus routing
   task cyc(input logic [7:0] s, input logic [15:0] a, input logic r);
      @(posedge core_clk);
      cyc_valid <= 1'b1;
      cyc_status <= s;
      cyc_addr <= a;
      cyc_data <= 8'h5A;
      @(negedge core_clk);
      chk(route_tgt, r, "route");
      chk(tgt_drive_en, r, "drive");
      chk(hbus_req, !r, "hbus");
      @(posedge core_clk);
      cyc_valid <= 1'b0;
   endtask : cyc
   // wait for the status copy to finish, bounded
   task brk;
      int n;
      n = 0;
      while (xfer_done !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 200) begin
         err_total++;
         conclude();
      end
      chk(xfer_req, 1, "xreq");
      @(posedge core_clk);
   endtask : brk
   // a start before the map is set would route blind, so map first
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      apb(0, etb_pkg::A_CTRL, 0);
      chk(q, etb_pkg::CTRL_RST, "ctrl");
      strap <= 1'b1;
      apb(0, etb_pkg::A_MMAP, 0);
      chk(q, etb_pkg::MAP_RST, "mmap");
      apb(0, etb_pkg::A_STAT, 0);
      chk(q[3], 0, "clksel");
      apb(0, 8'h3C, 0);
      chk(serr, 1, "slverr");
      apb(1, etb_pkg::A_BP0, 32'h00A2_1326);
      apb(0, etb_pkg::A_BP0, 0);
      chk(q, 32'h00A2_1326, "bp0");
      apb(1, etb_pkg::A_MMAP, 32'hFFFC_0002);
      apb(1, etb_pkg::A_CTRL, 32'h3);
      chk(emu_run, 0, "idle");
      apb(1, etb_pkg::A_CMD, 32'h1);
      @(negedge core_clk);
      chk(emu_run, 1, "run");
      chk(notify, 1, "notify");
      cyc(8'h00, 16'h1000, 1);
      cyc(8'h00, 16'h0010, 0);
      cyc(8'hA2, 16'h1326, 1);
      @(negedge core_clk);
      chk(emu_run, 0, "bpstop");
      chk(tgt_drive_en, 0, "nodrive");
      brk();
      apb(0, etb_pkg::A_STAT, 0);
      chk(q[13:8], 6'h01, "bpcause");
      chk(q[21:16], 6'h03, "count");
      apb(0, etb_pkg::A_PINS, 0);
      chk(q, 32'hA5, "pins");
      apb(1, etb_pkg::A_TIDX, 0);
      repeat (2) @(posedge core_clk);
      apb(0, etb_pkg::A_TDAT, 0);
      chk(q, 32'h0010_005A, "trace");
      apb(0, etb_pkg::A_TIMER, 0);
      t = q;
      repeat (30) @(posedge core_clk);
      apb(0, etb_pkg::A_TIMER, 0);
      chk(q, t, "timer");
      apb(1, etb_pkg::A_CMD, 32'h1);
      cyc(8'h00, 16'h2000, 0);
      brk();
      apb(0, etb_pkg::A_STAT, 0);
      chk(q[13:8], 6'h08, "guard");
      chk(q[2], 1, "error");
      cpu_active <= 1'b0;
      apb(1, etb_pkg::A_CMD, 32'h1);
      brk();
      apb(0, etb_pkg::A_STAT, 0);
      chk(q[13:8], 6'h10, "timeout");
      apb(1, etb_pkg::A_CTRL, 32'h8);
      apb(1, etb_pkg::A_CMD, 32'h1);
      repeat (40) @(posedge core_clk);
      chk(emu_run, 1, "tooff");
      // 45 more records wrap the store; record 5 becomes the oldest
      for (int i = 0; i < 45; i++) begin
         cyc(8'h00, 16'h1000 + 16'(i), 1);
      end
      probe <= 1'b1;
      brk();
      apb(0, etb_pkg::A_STAT, 0);
      chk(q[13:8], 6'h04, "probe");
      chk(q[21:16], 6'h2C, "full");
      apb(0, etb_pkg::A_TDAT, 0);
      chk(q, 32'h0010_015A, "oldest");
      apb(0, etb_pkg::A_TIMER, 0);
      // 131 running cycles hold 10 or 11 internal ticks
      chk(q >= 32'h0000_000A && q <= 32'h0000_000B, 1, "ticks");
      conclude();
   end
endmodule : emulation_trace_break_control_tb
`default_nettype wire
